/* File: lcc_pkg.sv */
// Constants shared by the logic cluster control block
package lcc_pkg;
  // ********************************
  // Structure
  // ********************************
  localparam int LCC_CELLS = 8;
  localparam int LCC_ROW_LINES = 6;
  localparam int LCC_SLOTS = 3;
  // ********************************
  // Register offsets (byte addresses)
  // ********************************
  localparam logic [7:0] LCC_A_CTRL = 8'h00;
  localparam logic [7:0] LCC_A_CLKCFG = 8'h04;
  localparam logic [7:0] LCC_A_STAT = 8'h08;
  localparam logic [7:0] LCC_A_MODE = 8'h0C;
  localparam logic [1:0] LCC_A_RCFG_HI = 2'h1;
  localparam logic [1:0] LCC_A_LUT_HI = 2'h2;
  localparam logic [7:0] LCC_A_Q = 8'hC0;
  // ********************************
  // Decode kinds
  // ********************************
  localparam logic [2:0] LCC_K_NONE = 3'h0;
  localparam logic [2:0] LCC_K_CTRL = 3'h1;
  localparam logic [2:0] LCC_K_CLK = 3'h2;
  localparam logic [2:0] LCC_K_STAT = 3'h3;
  localparam logic [2:0] LCC_K_MODE = 3'h4;
  localparam logic [2:0] LCC_K_RCFG = 3'h5;
  localparam logic [2:0] LCC_K_LUT = 3'h6;
  localparam logic [2:0] LCC_K_Q = 3'h7;
  // ********************************
  // Field positions
  // ********************************
  localparam int LCC_F_SLOT_STEP = 4;
  localparam int LCC_F_POL = 3;
  localparam int LCC_F_ACLR = 2;
  localparam int LCC_F_SCLR = 4;
  localparam int LCC_F_SLOAD = 5;
  localparam int LCC_F_ALOAD = 6;
  localparam int LCC_F_ALDATA = 7;
  localparam int LCC_F_SRC = 8;
  localparam logic [1:0] LCC_SLOT_NONE = 2'h3;
  localparam logic [1:0] LCC_SRC_ADD = 2'h1;
  localparam logic [1:0] LCC_SRC_CHAIN = 2'h2;
  // ********************************
  // Reset values
  // ********************************
  localparam logic [31:0] LCC_RST_CTRL = 32'h0000_0001;
  localparam logic [11:0] LCC_RST_CLKCFG = 12'h210;
  localparam logic [9:0] LCC_RST_RCFG = 10'h003;
endpackage

/* File: lcc_cluster_ctl.sv */
// Control-signal generation and cell registers of one logic cluster
// Notes on behaviour
// (R1) At most eleven control signals: three clocks, three enables, five clear/load.
// (R2) Three clock slots, yet never more than two distinct source lines.
// (R3) Each clock slot is tied to its own clock enable.
// (R4) Rising and falling edge of one line use two separate slots.
// (R5) A low clock enable blocks its slot so no register captures.
// (R6) Preset is an asynchronous load with load data held at one.
// (R7) While asynchronous load is in use, clock enable zero is unavailable.
// (R8) Controls come from the six row clock lines and local routing.
// (R9) Eight logic cells share the cluster controls and chains.
// (R10) Register chain feeds each register from the adjacent register.
// (R11) Each cell has two registers, two full adders and chain links.
// (R12) Cell takes eight inputs over two halves, or one six-input function.
// (R13) Each cell output is offered for fan-out to twenty-four cells.
// (R14) Asynchronous clear beats load, synchronous clear, sync load and data.
`timescale 1ns/1ns
module lcc_cluster_ctl import lcc_pkg::*; #(
  parameter int P_CELLS = LCC_CELLS // Logic cells in the cluster
) (
  input wire logic i_mclk, // System clock, 125 MHz
  input wire logic i_rst, // Asynchronous reset, active high
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB direction
  input wire logic [7:0] i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  output logic [31:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // APB error on unmapped address
  input wire logic [LCC_ROW_LINES-1:0] i_row_clk, // Row clock lines
  input wire logic [LCC_SLOTS-1:0] i_local_ena, // Local clock enables
  input wire logic [1:0] i_local_aclr, // Local asynchronous clears
  input wire logic i_local_sclr, // Local synchronous clear
  input wire logic i_local_aload, // Local asynchronous load
  input wire logic i_local_sload, // Local synchronous load
  input wire logic [8*P_CELLS-1:0] i_cell_in, // Eight inputs per cell
  input wire logic i_chain_in, // Register chain into register 0
  input wire logic i_carry_in, // Carry into cell 0
  output logic [2*P_CELLS-1:0] o_cell_q, // Cell register outputs
  output logic o_chain_out, // Register chain out of last register
  output logic o_carry_out // Registered carry out of last cell
);
  localparam int NREG = 2 * P_CELLS;

  // ********************************
  // Address decode
  // ********************************
  function automatic logic [2:0] addr_kind(input logic [7:0] a);
    logic [2:0] k;
    k = LCC_K_NONE;
    if (a == LCC_A_CTRL) k = LCC_K_CTRL;
    else if (a == LCC_A_CLKCFG) k = LCC_K_CLK;
    else if (a == LCC_A_STAT) k = LCC_K_STAT;
    else if (a == LCC_A_MODE) k = LCC_K_MODE;
    else if (a[7:6] == LCC_A_RCFG_HI && int'(a[5:2]) < NREG) k = LCC_K_RCFG;
    else if (a[7:6] == LCC_A_LUT_HI && int'(a[5:2]) < NREG) k = LCC_K_LUT;
    else if (a == LCC_A_Q) k = LCC_K_Q;
    return k;
  endfunction

  logic run_ff;
  logic [11:0] clkcfg_ff;
  logic [P_CELLS-1:0] mode_ff;
  logic [9:0] rcfg_ff [NREG];
  logic [31:0] lut_ff [NREG];
  logic [NREG-1:0] q_ff;
  logic [LCC_ROW_LINES-1:0] row_ff, row_prev_ff;
  logic pready_ff, pslverr_ff, carry_ff;
  logic [31:0] prdata_ff;
  logic [2:0] eff_line [LCC_SLOTS];
  logic [LCC_SLOTS-1:0] tick_raw, ena_eff, tick_g;
  logic clamp_w, aload_used;
  logic [NREG-1:0] d_w, tk_w, act_aclr, act_aload, nxt_q;
  logic carry_w;
  logic wr_w;
  logic [2:0] wkind;

  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_cell_q = q_ff; // R13
  assign o_chain_out = q_ff[NREG-1];
  assign o_carry_out = carry_ff;

  // ********************************
  // Cluster clock slots
  // ********************************
  // Row lines are sampled so that an edge shows as a one-cycle tick
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      row_ff <= '0;
      row_prev_ff <= '0;
    end else begin
      row_ff <= i_row_clk; // R8
      row_prev_ff <= row_ff;
    end
  end

  // A third distinct line folds onto slot one, so two sources at most
  always_comb begin
    eff_line[0] = clkcfg_ff[2:0];
    eff_line[1] = clkcfg_ff[LCC_F_SLOT_STEP +: 3];
    eff_line[2] = clkcfg_ff[2*LCC_F_SLOT_STEP +: 3];
    clamp_w = (eff_line[2] != eff_line[0]) && (eff_line[2] != eff_line[1])
      && (eff_line[0] != eff_line[1]);
    if (clamp_w) begin
      eff_line[2] = eff_line[1]; // R2
    end
  end

  // Edge polarity per slot; both edges of one line need two slots
  always_comb begin
    aload_used = 1'b0;
    for (int r = 0; r < NREG; r++) begin
      aload_used = aload_used | rcfg_ff[r][LCC_F_ALOAD];
    end
    for (int k = 0; k < LCC_SLOTS; k++) begin
      tick_raw[k] = 1'b0;
      if (int'(eff_line[k]) < LCC_ROW_LINES) begin
        tick_raw[k] = clkcfg_ff[k*LCC_F_SLOT_STEP+LCC_F_POL] ? // R4
          (row_prev_ff[eff_line[k]] & ~row_ff[eff_line[k]]) :
          (row_ff[eff_line[k]] & ~row_prev_ff[eff_line[k]]);
      end
      ena_eff[k] = i_local_ena[k]; // R3
    end
    // Enable zero is taken over by the load path, so slot zero runs ungated
    if (aload_used) begin
      ena_eff[0] = 1'b1; // R7
    end
    tick_g = tick_raw & ena_eff & {LCC_SLOTS{run_ff}}; // R5
  end

  // ********************************
  // Lookup halves and adders
  // ********************************
  // Carry ripples through all cells in one cycle; long clusters cost timing
  always_comb begin
    logic [7:0] ci;
    logic c1;
    logic cy;
    ci = '0;
    c1 = 1'b0;
    cy = i_carry_in;
    for (int c = 0; c < P_CELLS; c++) begin
      ci = i_cell_in[8*c +: 8]; // R9
      if (mode_ff[c]) begin
        d_w[2*c] = ci[5] ? lut_ff[2*c+1][ci[4:0]] : lut_ff[2*c][ci[4:0]]; // R12
        d_w[2*c+1] = d_w[2*c];
      end else begin
        d_w[2*c] = lut_ff[2*c][ci[3:0]]; // R12
        d_w[2*c+1] = lut_ff[2*c+1][ci[7:4]];
      end
      // Two full adders per cell on inputs 0/4 and 1/5
      if (rcfg_ff[2*c][LCC_F_SRC +: 2] == LCC_SRC_ADD) begin
        d_w[2*c] = ci[0] ^ ci[4] ^ cy; // R11
      end
      c1 = (ci[0] & ci[4]) | (cy & (ci[0] ^ ci[4]));
      if (rcfg_ff[2*c+1][LCC_F_SRC +: 2] == LCC_SRC_ADD) begin
        d_w[2*c+1] = ci[1] ^ ci[5] ^ c1; // R11
      end
      cy = (ci[1] & ci[5]) | (c1 & (ci[1] ^ ci[5]));
    end
    carry_w = cy;
  end

  // ********************************
  // Cell registers
  // ********************************
  // Priority: clear, then load, then clocked actions
  always_comb begin
    logic [9:0] cf;
    cf = '0;
    for (int i = 0; i < NREG; i++) begin
      cf = rcfg_ff[i];
      tk_w[i] = (cf[1:0] != LCC_SLOT_NONE) && tick_g[cf[1:0]]; // R3
      act_aclr[i] = (cf[LCC_F_ACLR +: 2] == 2'h1 && i_local_aclr[0])
        || (cf[LCC_F_ACLR +: 2] == 2'h2 && i_local_aclr[1]);
      act_aload[i] = cf[LCC_F_ALOAD] & i_local_aload;
      nxt_q[i] = q_ff[i];
      if (act_aclr[i]) begin
        nxt_q[i] = 1'b0; // R14
      end else if (act_aload[i]) begin
        nxt_q[i] = cf[LCC_F_ALDATA]; // R6
      end else if (tk_w[i]) begin
        if (cf[LCC_F_SCLR] && i_local_sclr) begin
          nxt_q[i] = 1'b0; // R14
        end else if (cf[LCC_F_SLOAD] && i_local_sload) begin
          nxt_q[i] = i_cell_in[8*(i/2)+7];
        end else if (cf[LCC_F_SRC +: 2] == LCC_SRC_CHAIN) begin
          nxt_q[i] = (i == 0) ? i_chain_in : q_ff[(i == 0) ? 0 : i-1]; // R10
        end else begin
          nxt_q[i] = d_w[i];
        end
      end
    end
  end

  // All sixteen registers and the carry out load together
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      q_ff <= '0;
      carry_ff <= 1'b0;
    end else begin
      q_ff <= nxt_q; // R1
      carry_ff <= carry_w;
    end
  end

  // ********************************
  // APB slave
  // ********************************
  // No wait state; read data and ready still come straight from flops
  assign wkind = addr_kind(i_paddr);
  assign wr_w = i_psel & i_penable & pready_ff & i_pwrite;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= i_psel & ~i_penable;
    end
  end

  // Read data is captured at the setup edge and held through access
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      prdata_ff <= '0;
      pslverr_ff <= 1'b0;
    end else if (i_psel && !i_penable) begin
      pslverr_ff <= (wkind == LCC_K_NONE);
      unique case (wkind)
        LCC_K_CTRL: prdata_ff <= {31'h0, run_ff};
        LCC_K_CLK: prdata_ff <= {20'h0, clkcfg_ff};
        LCC_K_STAT: prdata_ff <= {24'h0, clamp_w, aload_used, ena_eff, tick_g};
        LCC_K_MODE: prdata_ff <= 32'(mode_ff);
        LCC_K_RCFG: prdata_ff <= {22'h0, rcfg_ff[i_paddr[5:2]]};
        LCC_K_LUT: prdata_ff <= lut_ff[i_paddr[5:2]];
        LCC_K_Q: prdata_ff <= 32'(q_ff);
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Control and clock slot configuration
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      run_ff <= LCC_RST_CTRL[0];
      clkcfg_ff <= LCC_RST_CLKCFG;
      mode_ff <= '0;
    end else if (wr_w) begin
      if (wkind == LCC_K_CTRL) run_ff <= i_pwdata[0];
      if (wkind == LCC_K_CLK) clkcfg_ff <= i_pwdata[11:0];
      if (wkind == LCC_K_MODE) mode_ff <= i_pwdata[P_CELLS-1:0];
    end
  end

  // Per-register configuration and truth tables
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < NREG; i++) begin
        rcfg_ff[i] <= LCC_RST_RCFG;
        lut_ff[i] <= '0;
      end
    end else if (wr_w) begin
      if (wkind == LCC_K_RCFG) rcfg_ff[i_paddr[5:2]] <= i_pwdata[9:0];
      if (wkind == LCC_K_LUT) lut_ff[i_paddr[5:2]] <= i_pwdata;
    end
  end

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  aclr_wins_a: assert property (act_aclr[3] |=> !q_ff[3]) // R14
    else $error("clear did not win on register 3");
  preset_load_a: assert property ( // R6
    act_aload[3] && !act_aclr[3] |=> q_ff[3] == $past(rcfg_ff[3][LCC_F_ALDATA]))
    else $error("asynchronous load value not taken");
  gated_hold_a: assert property ( // R5
    !tk_w[0] && !act_aclr[0] && !act_aload[0] |=> $stable(q_ff[0]))
    else $error("register changed without tick");
  ena_block_a: assert property ( // R3
    rcfg_ff[1][1:0] == 2'h1 && !i_local_ena[1] |-> !tk_w[1])
    else $error("slot one ticked with enable one low");
  two_src_a: assert property ( // R2
    eff_line[2] == eff_line[0] || eff_line[2] == eff_line[1] || eff_line[0] == eff_line[1])
    else $error("three distinct clock sources");
  ena_zero_a: assert property (aload_used |-> ena_eff[0]) // R7
    else $error("enable zero still gating under load");
  edge_pol_a: assert property ( // R4
    tick_raw[0] |-> row_ff[eff_line[0]] == !clkcfg_ff[LCC_F_POL])
    else $error("tick on wrong edge");
  chain_a: assert property ( // R10
    tk_w[2] && rcfg_ff[2][9:2] == 8'h80 && !i_local_aload |=> q_ff[2] == $past(q_ff[1]))
    else $error("register chain did not shift");
  sclr_a: assert property ( // R14
    tk_w[0] && rcfg_ff[0][LCC_F_SCLR] && i_local_sclr && !act_aload[0] |=> !q_ff[0])
    else $error("synchronous clear ignored");
  apb_ready_a: assert property (i_psel && !i_penable |=> pready_ff ##1 !pready_ff)
    else $error("ready not a single pulse after setup");

  chain_shift_c: cover property (tk_w[2] && rcfg_ff[2][9:8] == LCC_SRC_CHAIN);
  preset_c: cover property (act_aload[0] && rcfg_ff[0][LCC_F_ALDATA]);
  both_edges_c: cover property (tick_g[0] ##[1:20] tick_g[1]);
  clamp_c: cover property (clamp_w && tick_raw[2]);
endmodule

/* File: lcc_fabric_model.sv */
// Row clock network model that drives the cluster's row lines
`timescale 1ns/1ns
module lcc_fabric_model (
  input wire logic i_mclk, // Fabric clock
  input wire logic i_rst, // Reset, active high
  input wire logic [5:0] i_flip, // Lines to toggle at the next edge
  output logic [5:0] o_row_clk // Row clock lines
);
  // Lines stand still between requests, so every edge seen is one we asked for
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_row_clk <= 6'h00;
    end else begin
      o_row_clk <= o_row_clk ^ i_flip;
    end
  end
endmodule

/* File: test_logic_cluster_control_signals.sv */
// Self-checking bench for the logic cluster control block
`timescale 1ns/1ns
module test_logic_cluster_control_signals import lcc_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  logic [5:0] flip = 6'h00;
  logic [5:0] row;
  logic [2:0] ena = 3'h0;
  logic [1:0] aclr = 2'h0;
  logic aload = 1'b0;
  logic sclr = 1'b0;
  logic sload = 1'b0;
  logic chin = 1'b0;
  logic [63:0] cell_in = 64'h0;
  logic chout, cout;
  logic [15:0] q;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  // Reset read rows: address, expected data, expected error
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h40, 8'h0C, 8'h10};
  logic [31:0] rv [5] = '{32'h1, 32'h210, 32'h3, 32'h0, 32'h0};
  logic re [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  // Setup writes: all-ones tables, slot 0, slot 1, chain source
  logic [7:0] wa [5] = '{8'h80, 8'h84, 8'h40, 8'h44, 8'h48};
  logic [31:0] wd [5] = '{32'hFFFF, 32'hFFFF, 32'h0, 32'h1, 32'h200};

  // 125 MHz clock
  always #4 clk = ~clk;

  // Hang guard: far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  lcc_fabric_model fab_u (
    .i_mclk(clk),
    .i_rst(rst),
    .i_flip(flip),
    .o_row_clk(row)
  );

  lcc_cluster_ctl dut_u (
    .i_mclk(clk),
    .i_rst(rst),
    .i_psel(psel),
    .i_penable(pen),
    .i_pwrite(pwr),
    .i_paddr(paddr),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .i_row_clk(row),
    .i_local_ena(ena),
    .i_local_aclr(aclr),
    .i_local_sclr(sclr),
    .i_local_aload(aload),
    .i_local_sload(sload),
    .i_cell_in(cell_in),
    .i_chain_in(chin),
    .i_carry_in(1'b0),
    .o_cell_q(q),
    .o_chain_out(chout),
    .o_carry_out(cout)
  );

  // ****************
  // Tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // One toggle of a row line, then time for the tick to land
  task automatic flip_line(input int l);
    @(posedge clk);
    flip <= 6'h01 << l;
    @(posedge clk);
    flip <= 6'h00;
    repeat (5) @(posedge clk);
  endtask

  task automatic pulse(input int l);
    flip_line(l);
    flip_line(l);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk("rdata", rd, rv[i]);
      chk("err", 32'(er), 32'(re[i]));
    end
    apb(1'b1, 8'h10, 32'hFFFF);
    chk("wr err", 32'(er), 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk("fold", 32'(rd[7]), 32'h1);
    for (int i = 0; i < 5; i++) apb(1'b1, wa[i], wd[i]);
    // Gated clock enable holds the registers
    pulse(0);
    chk("q", 32'(q), 32'h0);
    ena <= 3'h1;
    pulse(0);
    chk("q", 32'(q), 32'h1);
    // Slot one follows its own enable only
    pulse(1);
    chk("q", 32'(q), 32'h1);
    ena <= 3'h2;
    pulse(1);
    chk("q", 32'(q), 32'h3);
    ena <= 3'h1;
    pulse(0);
    chk("q", 32'(q), 32'h7);
    // Falling edge of line 0 in slot 1
    apb(1'b1, 8'h04, 32'h280);
    apb(1'b1, 8'h50, 32'h1);
    apb(1'b1, 8'h90, 32'hFFFF);
    ena <= 3'h2;
    flip_line(0);
    chk("q", 32'(q), 32'h7);
    flip_line(0);
    chk("q", 32'(q), 32'h17);
    apb(1'b0, 8'h08, 32'h0);
    chk("fold", 32'(rd[7]), 32'h0);
    // Clear beats load; unselected clear lets the preset through
    apb(1'b1, 8'h4C, 32'hC4);
    aload <= 1'b1;
    aclr <= 2'h1;
    repeat (3) @(posedge clk);
    chk("q", 32'(q), 32'h17);
    aclr <= 2'h2;
    repeat (3) @(posedge clk);
    chk("q", 32'(q), 32'h1F);
    apb(1'b0, 8'h08, 32'h0);
    chk("stat", 32'(rd[6:3]), 32'hB);
    aload <= 1'b0;
    // Adders on registers 0 and 1; every cell generates a carry
    apb(1'b1, 8'h40, 32'h100);
    apb(1'b1, 8'h44, 32'h100);
    cell_in <= {8{8'h33}};
    ena <= 3'h7;
    pulse(0);
    chk("q add", 32'(q[1:0]), 32'h2);
    chk("carry", 32'(cout), 32'h1);
    // Synchronous clear wins over the adder result
    apb(1'b1, 8'h40, 32'h110);
    apb(1'b1, 8'h44, 32'h110);
    sclr <= 1'b1;
    pulse(0);
    chk("q sclr", 32'(q[1:0]), 32'h0);
    // Synchronous load takes bit 7 of the cell's inputs
    apb(1'b1, 8'h44, 32'h120);
    sclr <= 1'b0;
    sload <= 1'b1;
    cell_in[7:0] <= 8'hB3;
    pulse(0);
    chk("q sload", 32'(q[1:0]), 32'h2);
    // Chain input feeds register 0
    apb(1'b1, 8'h40, 32'h200);
    chin <= 1'b1;
    pulse(0);
    chk("q chain", 32'(q[1:0]), 32'h3);
    chk("chain out", 32'(chout), 32'h0);
    tally_and_finish();
  end
endmodule
